// ==== rtl/mtxes_map.vh ====
// Register offsets, field layouts and reset values of the transmit statistics bank
`ifndef MTXES_MAP_VH
`define MTXES_MAP_VH
`define MTXES_ADDR_W 16
`define MTXES_LARGE_FRAMES_OFS 16'h003A
`define MTXES_UNDERFLOW_OFS 16'h003B
`define MTXES_ONE_COL_OFS 16'h003C
`define MTXES_MANY_COL_OFS 16'h003D
`define MTXES_COL_ABORT_OFS 16'h003E
`define MTXES_LARGE_W 32
`define MTXES_UNDERFLOW_W 10
`define MTXES_ONE_COL_W 18
`define MTXES_MANY_COL_W 18
`define MTXES_COL_ABORT_W 10
`define MTXES_LARGE_FRAME_MIN 16'h0400
`define MTXES_COUNT_RESET 32'h00000000
`define MTXES_LARGE_MAX 32'h0FFFFFFF
`define MTXES_UNDERFLOW_MAX 32'h000003FF
`define MTXES_ONE_COL_MAX 32'h00003FFF
`define MTXES_MANY_COL_MAX 32'h00003FFF
`define MTXES_COL_ABORT_MAX 32'h000003FF
`endif

// ==== rtl/mtxes_tx_error_statistics.v ====
// Read-clear saturating transmit statistic counters of the MAC
`timescale 1ns/100ps
`include "mtxes_map.vh"

module mtxes_tx_error_statistics (
  input wire sys_clk_in,
  input wire reset_n_in,
  input wire tx_done_ok_in,
  input wire [15:0] tx_frame_len_in,
  input wire tx_underflow_abort_in,
  input wire cut_through_en_in,
  input wire plca_en_in,
  input wire [4:0] tx_phys_col_count_in,
  input wire [4:0] tx_logic_col_count_in,
  input wire tx_col_abort_in,
  input wire reg_rd_in,
  input wire [`MTXES_ADDR_W-1:0] reg_addr_in,
  output reg [31:0] reg_rdata_out,
  output reg reg_hit_out
);

  localparam NCNT = 5;

  // Position of each counter in the bank
  localparam IDX_LARGE = 0;
  localparam IDX_UNDERFLOW = 1;
  localparam IDX_ONE_COL = 2;
  localparam IDX_MANY_COL = 3;
  localparam IDX_COL_ABORT = 4;

  // Collision count of the sent frame: logical ones from the RS when PLCA runs
  wire [4:0] col_count;
  assign col_count = plca_en_in ? tx_logic_col_count_in : tx_phys_col_count_in;

  wire single_col;
  wire multi_col;
  assign single_col = (col_count == 5'h01);
  assign multi_col = (col_count > 5'h01);

  wire large_frame;
  assign large_frame = (tx_frame_len_in >= `MTXES_LARGE_FRAME_MIN);

  wire large_evt;
  wire underflow_evt;
  wire one_col_evt;
  wire many_col_evt;
  wire col_abort_evt;

  assign large_evt = tx_done_ok_in && large_frame;

  // Outside cut-through the whole frame is buffered, so an underflow cannot be real
  assign underflow_evt = tx_underflow_abort_in && cut_through_en_in;

  assign one_col_evt = tx_done_ok_in && single_col;

  // Nonzero here flags a PLCA misconfiguration; no special handling
  assign many_col_evt = tx_done_ok_in && multi_col;

  assign col_abort_evt = tx_col_abort_in;

  wire [NCNT-1:0] evt;
  assign evt[IDX_LARGE] = large_evt;
  assign evt[IDX_UNDERFLOW] = underflow_evt;
  assign evt[IDX_ONE_COL] = one_col_evt;
  assign evt[IDX_MANY_COL] = many_col_evt;
  assign evt[IDX_COL_ABORT] = col_abort_evt;

  wire [NCNT-1:0] sel;
  assign sel[IDX_LARGE] = (reg_addr_in == `MTXES_LARGE_FRAMES_OFS);
  assign sel[IDX_UNDERFLOW] = (reg_addr_in == `MTXES_UNDERFLOW_OFS);
  assign sel[IDX_ONE_COL] = (reg_addr_in == `MTXES_ONE_COL_OFS);
  assign sel[IDX_MANY_COL] = (reg_addr_in == `MTXES_MANY_COL_OFS);
  assign sel[IDX_COL_ABORT] = (reg_addr_in == `MTXES_COL_ABORT_OFS);

  wire [NCNT-1:0] rd_clr;
  assign rd_clr = sel & {NCNT{reg_rd_in}};

  // Counts widened to 32 bits; upper bits of narrow fields are constant zero
  wire [31:0] cnt_view [0:NCNT-1];
  wire [NCNT-1:0] at_max;

  genvar g;
  generate
    for (g = 0; g < NCNT; g = g + 1) begin : g_cnt
      localparam integer W = (g == 0) ? `MTXES_LARGE_W :
                             (g == 1) ? `MTXES_UNDERFLOW_W :
                             (g == 4) ? `MTXES_COL_ABORT_W : `MTXES_ONE_COL_W;
      // Stop level is the documented maximum, not always all ones of the field
      localparam [31:0] MAXV = (g == 0) ? `MTXES_LARGE_MAX :
                               (g == 1) ? `MTXES_UNDERFLOW_MAX :
                               (g == 2) ? `MTXES_ONE_COL_MAX :
                               (g == 3) ? `MTXES_MANY_COL_MAX : `MTXES_COL_ABORT_MAX;

      reg [W-1:0] cnt_q;
      reg [W-1:0] cnt_d;
      wire [W-1:0] sat_lvl;
      wire [W-1:0] one_w;

      assign sat_lvl = MAXV[W-1:0];
      assign one_w = {{(W-1){1'b0}}, 1'b1};
      assign at_max[g] = (cnt_q >= sat_lvl);

      always @* begin
        cnt_d = cnt_q;
        if (rd_clr[g]) begin
          // Set wins over clear: an event in the read cycle survives as one
          cnt_d = evt[g] ? one_w : {W{1'b0}};
        end else if (evt[g] && !at_max[g]) begin
          cnt_d = cnt_q + one_w;
        end
      end

      always @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          cnt_q <= {W{1'b0}};
        end else begin
          cnt_q <= cnt_d;
        end
      end

      if (W < 32) begin : g_pad
        assign cnt_view[g] = {{(32-W){1'b0}}, cnt_q};
      end else begin : g_full
        assign cnt_view[g] = cnt_q;
      end
    end
  endgenerate

  // Read data registered: value before the clear is returned
  reg [31:0] rdata_d;
  reg hit_d;

  always @* begin
    rdata_d = `MTXES_COUNT_RESET;
    hit_d = 1'b0;
    case (reg_addr_in)
      `MTXES_LARGE_FRAMES_OFS: begin
        rdata_d = cnt_view[IDX_LARGE];
        hit_d = 1'b1;
      end
      `MTXES_UNDERFLOW_OFS: begin
        rdata_d = cnt_view[IDX_UNDERFLOW];
        hit_d = 1'b1;
      end
      `MTXES_ONE_COL_OFS: begin
        rdata_d = cnt_view[IDX_ONE_COL];
        hit_d = 1'b1;
      end
      `MTXES_MANY_COL_OFS: begin
        rdata_d = cnt_view[IDX_MANY_COL];
        hit_d = 1'b1;
      end
      `MTXES_COL_ABORT_OFS: begin
        rdata_d = cnt_view[IDX_COL_ABORT];
        hit_d = 1'b1;
      end
      default: begin
        // Unmapped words read zero so software sees no stale data
        rdata_d = `MTXES_COUNT_RESET;
        hit_d = 1'b0;
      end
    endcase
  end

  // Read data holds until the next read; software may sample it late
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= `MTXES_COUNT_RESET;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rdata_d;
    end
  end

  // Hit is a one-cycle pulse per accepted read
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_hit_out <= 1'b0;
    end else if (reg_rd_in) begin
      reg_hit_out <= hit_d;
    end else begin
      reg_hit_out <= 1'b0;
    end
  end

  // Any counter pinned at its stop level; kept for debug visibility only
  wire any_at_max;
  assign any_at_max = |at_max;

endmodule

// ==== tb/mtxes_chk.sv ====
// Read port checker
`timescale 1ns/100ps
module mtxes_chk (input wire sys_clk_in, reset_n_in, tx_done_ok_in, reg_rd_in, reg_hit_out,
  input wire [15:0] reg_addr_in, input wire [31:0] reg_rdata_out);
  wire [15:0] a = reg_addr_in - 16'h003A;
  wire [31:0] d = reg_rdata_out;
  wire r = reg_rd_in, h = reg_hit_out, m = a < 5;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_rd; r && !a && !tx_done_ok_in; endsequence
  AST_HIT: assert property (r && m |=> h) else $error("no hit");
  AST_MISS: assert property (r && !m |=> !h && !d) else $error("miss");
  AST_IDLE: assert property (!r |=> !h && $stable(d)) else $error("idle");
  AST_UF: assert property (r && a == 1 |=> !d[31:10]) else $error("uf");
  AST_ONE: assert property (r && a == 2 |=> !d[31:18]) else $error("one");
  AST_MANY: assert property (r && a == 3 |=> !d[31:18]) else $error("many");
  AST_CA: assert property (r && a == 4 |=> !d[31:10]) else $error("ca");
  AST_CLR: assert property (s_rd ##1 s_rd |=> !d) else $error("clr");
endmodule

// ==== tb/test_mtxes_tx_error_statistics.sv ====
// Statistics bench
`timescale 1ns/100ps
module test_mtxes_tx_error_statistics;
  logic sys_clk_in = 0, reset_n_in = 0, tx_done_ok_in = 0, tx_underflow_abort_in = 0, h = 0;
  logic cut_through_en_in = 0, plca_en_in = 0, tx_col_abort_in = 0, reg_rd_in = 0, reg_hit_out;
  logic [15:0] tx_frame_len_in = 0, reg_addr_in = 0;
  logic [4:0] tx_phys_col_count_in = 0, tx_logic_col_count_in = 0, c, e;
  logic [31:0] reg_rdata_out, d = 0, m[5] = '{default: 0};
  logic [31:0] x[5] = '{32'h0FFFFFFF, 32'h3FF, 32'h3FFF, 32'h3FFF, 32'h3FF};
  int num_errors = 0, cmp_count = 0, t = 0;
  mtxes_tx_error_statistics i_dut (.*);
  initial forever #12.5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) if (++t > 4000) begin num_errors++; conclude; end
  task automatic cmp(string n, logic [31:0] v, s);
    cmp_count++;
    if (s !== v) begin num_errors++; $display("[ERR] %s exp %h got %h", n, v, s); end
  endtask
  task automatic conclude;
    $display("errors %0d of %0d", num_errors, cmp_count);
    if (!num_errors && cmp_count) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    void'($urandom(71));
    repeat (8) @(negedge sys_clk_in);
    reset_n_in = 1;
    for (int n = 0; n < 3000; n++) begin
      @(negedge sys_clk_in);
      cmp("rdata", d, reg_rdata_out);
      cmp("hit", h, reg_hit_out);
      {tx_done_ok_in, plca_en_in, tx_phys_col_count_in, tx_logic_col_count_in} = $urandom;
      // Forced aborts early on drive the 10-bit underflow and collision-abort counters into saturation
      {tx_underflow_abort_in, tx_col_abort_in, cut_through_en_in} = $urandom | {3{n < 2000}};
      tx_frame_len_in = 1022 + $urandom % 4;
      reg_rd_in = n > 1999 && $urandom % 2;
      reg_addr_in = 57 + $urandom % 7;
      h = reg_rd_in && reg_addr_in - 58 < 5;
      if (reg_rd_in) d = h ? m[reg_addr_in - 58] : 0;
      if (h) m[reg_addr_in - 58] = 0;
      c = plca_en_in ? tx_logic_col_count_in : tx_phys_col_count_in;
      e = {tx_col_abort_in, tx_done_ok_in && c > 1, tx_done_ok_in && c == 1,
        tx_underflow_abort_in && cut_through_en_in, tx_done_ok_in && tx_frame_len_in > 1023};
      foreach (m[i]) if (e[i] && m[i] != x[i]) m[i]++;
    end
    conclude;
  end
endmodule
bind mtxes_tx_error_statistics mtxes_chk i_chk (.*);
